// [rtl/irq_mask_regs.vh]
`ifndef IRQ_MASK_REGS_VH
`define IRQ_MASK_REGS_VH
// register address on the serial control interface (7-bit)
`define MASK_ADDR 7'h09
`define MASK_W 16
`define MASK_POR 16'h0140
`define MASK_KEEP 16'h01FF
// field positions
`define B_PERIODIC 8
`define B_WD_OFF 7
`define B_WD_FAIL 6
`define B_SERIAL_ERR 5
`define B_BRIDGE 4
`define B_HIGHSIDE 3
`define B_BUS 2
`define B_TEMP 1
`define B_SUPPLY 0
`define N_SRC 7
// timing defaults, in cycles of the 10 MHz clock
`define PULSE_CYC 16'h000A
`define PERIOD_CYC 24'h002710
`endif

// [rtl/irq_pulse_gen.v]
`timescale 1ns/1ps
`include "irq_mask_regs.vh"
// fixed-length active-low pulses on start requests; all requests that
// arrive while a pulse is out collapse into one held request, replayed afterwards
module irq_pulse_gen #(
  parameter [15:0] PULSE_LEN = `PULSE_CYC
) (
  input wire clk,
  input wire reset_n,
  input wire start,
  output wire busy,
  output reg line_n
);
  reg [15:0] cnt_q;
  reg pend_q;
  assign busy = (cnt_q != 16'h0000);
  ////////////////////////////////////////////////////////////////////////
  // pulse counter and one held request
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= 16'h0000;
      pend_q <= 1'b0;
      line_n <= 1'b1;
    end else begin
      if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
        line_n <= (cnt_q == 16'h0001);
        if (start)
          pend_q <= 1'b1;
      end else if (start || pend_q) begin
        cnt_q <= PULSE_LEN;
        line_n <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        line_n <= 1'b1;
      end
    end
  end
endmodule // irq_pulse_gen

// [rtl/irq_mask_and_event_gen.v]
`timescale 1ns/1ps
`include "irq_mask_regs.vh"
module irq_mask_and_event_gen #(
  parameter [15:0] PULSE_LEN = `PULSE_CYC,
  parameter [23:0] PERIOD_LEN = `PERIOD_CYC
) (
  input wire clk,
  input wire reset_n,
  input wire soft_reset,
  input wire restart_entry,
  input wire reg_wr,
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire devmode,
  input wire wdog_fail,
  input wire serial_frame_err,
  input wire checksum_err,
  input wire bridge_summary,
  input wire highside_summary,
  input wire bus_summary,
  input wire temp_summary,
  input wire supply_summary,
  input wire irq_pending,
  output reg wdog_active,
  output wire irq_line_n
);
  reg [15:0] mask_q;
  reg [15:0] mask_d;
  reg [23:0] per_q;
  wire [`N_SRC-1:0] src;
  wire [`N_SRC-1:0] en;
  wire [`N_SRC-1:0] ev;
  wire start;
  wire hit;
  wire periodic_irq_enable;
  wire devmode_wdog_off;
  wire devmode_wdog_fail_irq;
  wire bridge_summary_irq;
  wire highside_summary_irq;

  function mask_sel;
    input [6:0] a;
    begin
      mask_sel = (a == `MASK_ADDR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mask register
  assign hit = mask_sel(reg_addr);
  always @* begin
    mask_d = mask_q;
    if (restart_entry)
      mask_d = mask_q & `MASK_KEEP;
    else if (reg_wr && hit)
      mask_d = reg_wdata & `MASK_KEEP;
  end

  // power-on and soft reset both load the default pattern
  always @(posedge clk) begin
    if (!reset_n || soft_reset)
      mask_q <= `MASK_POR;
    else
      mask_q <= mask_d;
  end

  // read data from flip-flops; unmapped addresses read zero
  always @(posedge clk) begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (hit)
      reg_rdata <= mask_q & `MASK_KEEP;
    else
      reg_rdata <= 16'h0000;
  end

  assign periodic_irq_enable = mask_q[`B_PERIODIC];
  assign devmode_wdog_off = mask_q[`B_WD_OFF];
  assign devmode_wdog_fail_irq = mask_q[`B_WD_FAIL];
  assign bridge_summary_irq = mask_q[`B_BRIDGE];
  assign highside_summary_irq = mask_q[`B_HIGHSIDE];

  ////////////////////////////////////////////////////////////////////////
  // watchdog gate in development mode
  always @(posedge clk) begin
    if (!reset_n)
      wdog_active <= 1'b1;
    else
      wdog_active <= !(devmode && devmode_wdog_off);
  end

  ////////////////////////////////////////////////////////////////////////
  // event sources: inputs are one-cycle occurrence pulses, so a repeat
  // with the status bit still set is seen again
  assign src[0] = supply_summary;
  assign src[1] = temp_summary;
  assign src[2] = bus_summary;
  assign src[3] = highside_summary;
  assign src[4] = bridge_summary;
  assign src[5] = serial_frame_err | checksum_err;
  assign src[6] = wdog_fail & devmode;
  assign en = {devmode_wdog_fail_irq, mask_q[`B_SERIAL_ERR],
    bridge_summary_irq, highside_summary_irq, mask_q[`B_BUS],
    mask_q[`B_TEMP], mask_q[`B_SUPPLY]};

  genvar i;
  generate
    for (i = 0; i < `N_SRC; i = i + 1) begin : g_src
      assign ev[i] = src[i] & en[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // periodic re-signalling while interrupts pend
  always @(posedge clk) begin
    if (!reset_n)
      per_q <= 24'h000000;
    else if (!(periodic_irq_enable && irq_pending) || (|ev))
      per_q <= 24'h000000;
    else if (per_q >= PERIOD_LEN - 24'h000001)
      per_q <= 24'h000000;
    else
      per_q <= per_q + 24'h000001;
  end

  assign start = (|ev) || (periodic_irq_enable && irq_pending &&
    (per_q == PERIOD_LEN - 24'h000001));

  ////////////////////////////////////////////////////////////////////////
  // line pulse generator
  irq_pulse_gen #(
    .PULSE_LEN(PULSE_LEN)
  ) u_pulse (
    .clk(clk),
    .reset_n(reset_n),
    .start(start),
    .busy(),
    .line_n(irq_line_n)
  );
endmodule // irq_mask_and_event_gen

// [testbench/irq_event_checker.sv]
`timescale 1ns/1ps
module irq_event_checker (
  input wire clk,
  input wire reset_n,
  input wire soft_reset,
  input wire restart_entry,
  input wire reg_wr,
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire devmode,
  input wire wdog_active,
  input wire irq_line_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_pulse; (!irq_line_n)[*3] ##1 irq_line_n; endsequence
  sequence s_wr;
    reg_wr && reg_addr == 7'h09 && !soft_reset && !restart_entry;
  endsequence
  property p_rst;
    disable iff (1'b0) !reset_n |=> irq_line_n && wdog_active;
  endproperty
  property p_len; $fell(irq_line_n) |-> s_pulse; endproperty
  property p_gap; $rose(irq_line_n) |-> !$past(irq_line_n, 3); endproperty
  property p_resv; reg_rdata[15:9] == 7'h00; endproperty
  property p_oth; reg_addr != 7'h09 |=> reg_rdata == 16'h0000; endproperty
  property p_wr;
    s_wr ##1 reg_addr == 7'h09 |=> reg_rdata == ($past(reg_wdata, 2) & 16'h01FF);
  endproperty
  property p_wdon; !devmode |=> wdog_active; endproperty
  property p_wdoff; s_wr ##0 reg_wdata[7] ##1 devmode[*2] |-> !wdog_active;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_len: assert property (p_len) else $error("pulse length");
  a_gap: assert property (p_gap) else $error("pulse gap");
  a_resv: assert property (p_resv) else $error("reserved bits");
  a_oth: assert property (p_oth) else $error("other address");
  a_wr: assert property (p_wr) else $error("mask write");
  a_wdon: assert property (p_wdon) else $error("wdog on");
  a_wdoff: assert property (p_wdoff) else $error("wdog off");
endmodule // irq_event_checker
bind irq_mask_and_event_gen irq_event_checker u_chk (.*);

// [testbench/irq_host_model.sv]
`timescale 1ns/1ps
// host edge input: counts falling edges of the interrupt line
module irq_host_model (
  input wire clk,
  input wire irq_line_n,
  output logic [15:0] edges
);
  logic last_q = 1'b1;
  initial edges = 16'h0000;
  always @(posedge clk) begin
    last_q <= irq_line_n;
    if (last_q && !irq_line_n) edges <= edges + 16'h0001;
  end
endmodule // irq_host_model

// [testbench/irq_mask_and_event_gen_tb.sv]
`timescale 1ns/1ps
module irq_mask_and_event_gen_tb;
  logic clk = 0, reset_n = 0, soft_reset = 0, restart_entry = 0, reg_wr = 0;
  logic devmode = 1, irq_pending = 0;
  logic [6:0] reg_addr = 7'h09;
  logic [15:0] reg_wdata = 16'h0000, n0;
  logic [7:0] s = 8'h00;
  wire [15:0] reg_rdata, edges;
  wire wdog_active, irq_line_n;
  int fails = 0, tests_run = 0;
  always #50 clk = ~clk;
  irq_mask_and_event_gen #(.PULSE_LEN(16'h0003), .PERIOD_LEN(24'h000032))
  u_dut (.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .restart_entry(restart_entry), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .devmode(devmode),
    .wdog_fail(s[6]), .serial_frame_err(s[5]), .checksum_err(s[7]),
    .bridge_summary(s[4]), .highside_summary(s[3]), .bus_summary(s[2]),
    .temp_summary(s[1]), .supply_summary(s[0]), .irq_pending(irq_pending),
    .wdog_active(wdog_active), .irq_line_n(irq_line_n));
  irq_host_model u_host (.clk(clk), .irq_line_n(irq_line_n), .edges(edges));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input [15:0] d, input [6:0] a = 7'h09);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
    reg_addr = 7'h09;
  endtask
  task rd(input [15:0] e);
    repeat (2) @(negedge clk);
    chk("mask", reg_rdata, e);
  endtask
  task ev(input int b, input [15:0] e);
    n0 = edges;
    @(negedge clk);
    s[b] = 1;
    @(negedge clk);
    s = 8'h00;
    repeat (8) @(negedge clk);
    chk("pulses", edges - n0, e);
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1;
    rd(16'h0140);
    wr(16'hFFFF);
    rd(16'h01FF);
    wr(16'h0000, 7'h05);
    rd(16'h01FF);
    for (int b = 0; b < 8; b++) begin
      wr(16'h0001 << (b > 6 ? 5 : b));
      ev(b, 1);
      ev(b, 1);
      wr(0);
      ev(b, 0);
    end
    wr(16'h0080);
    repeat (2) @(negedge clk);
    chk("wdog", 16'(wdog_active), 0);
    devmode = 0;
    repeat (2) @(negedge clk);
    chk("wdog", 16'(wdog_active), 1);
    wr(16'h0040);
    ev(6, 0);
    wr(16'h0100);
    irq_pending = 1;
    n0 = edges;
    repeat (130) @(negedge clk);
    chk("periodic", 16'(edges - n0 >= 2), 1);
    irq_pending = 0;
    repeat (5) @(negedge clk);
    n0 = edges;
    repeat (120) @(negedge clk);
    chk("periodic", edges - n0, 0);
    wr(16'h01AA);
    restart_entry = 1;
    @(negedge clk);
    restart_entry = 0;
    rd(16'h01AA);
    soft_reset = 1;
    @(negedge clk);
    soft_reset = 0;
    rd(16'h0140);
    $display("tests done");
    give_verdict;
  end
  // watchdog against a hang
  initial begin
    #500000;
    fails++;
    give_verdict;
  end
endmodule // irq_mask_and_event_gen_tb
